//--- verilog/ptv_params.svh
/*
 * Register offsets, field positions and reset values for the target window block.
 * Assumes byte addressing on a 32-bit register bus.
 */
`ifndef PTV_PARAMS_SVH
`define PTV_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define PTV_OFF_IMG6_CTL   12'h1C8
`define PTV_OFF_IMG6_BASE  12'h1CC
`define PTV_OFF_IMG6_BOUND 12'h1D0
`define PTV_OFF_IMG6_XOFF  12'h1D4
`define PTV_OFF_IMG7_CTL   12'h1DC
`define PTV_OFF_IMG7_BASE  12'h1E0
`define PTV_OFF_IMG7_BOUND 12'h1E4
`define PTV_OFF_IMG7_XOFF  12'h1E8

// ----------------------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------------------
`define PTV_CTL_EN_BIT     31
`define PTV_CTL_POSTED_WRITE_ALLOW_BIT   30
`define PTV_CTL_VDW_HI     23
`define PTV_CTL_VDW_LO     22
`define PTV_CTL_VAS_HI     18
`define PTV_CTL_VAS_LO     16
`define PTV_CTL_PGM_BIT    14
`define PTV_CTL_SUP_BIT    12
`define PTV_CTL_VCT_BIT    8
`define PTV_CTL_LAS_BIT    0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PTV_RST_VDW        2'h2
`define PTV_RST_ADDR       16'h0000

`endif

//--- verilog/ptv_pkg.sv
/*
 * Types shared by the target window block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ptv_pkg;

   typedef enum logic [1:0] {
      PTV_W8  = 2'h0,
      PTV_W16 = 2'h1,
      PTV_W32 = 2'h2,
      PTV_W64 = 2'h3
   } ptv_width_t;

   typedef enum logic [2:0] {
      PTV_A16   = 3'h0,
      PTV_A24   = 3'h1,
      PTV_A32   = 3'h2,
      PTV_RSV3  = 3'h3,
      PTV_RSV4  = 3'h4,
      PTV_CRCSR = 3'h5,
      PTV_USER1 = 3'h6,
      PTV_USER2 = 3'h7
   } ptv_space_t;

   typedef struct packed {
      logic       window_on;
      logic       posted_write_allow;
      ptv_width_t max_vme_width;
      ptv_space_t vme_space_select;
      logic       program_data_select;
      logic       supervisor_select;
      logic       block_transfer_allow;
      logic       pci_space_select;
   } ptv_ctl_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] addr;
      logic        is_io;
      logic        is_write;
   } ptv_pci_req_t;

   typedef struct packed {
      logic        hit;
      logic        image;
      logic [31:0] vme_addr;
      ptv_width_t  width;
      ptv_space_t  space;
      logic        program_am;
      logic        super_am;
      logic        blt_use;
      logic        mblt_allow;
      logic        posted;
      logic        space_bad;
   } ptv_vme_req_t;

endpackage : ptv_pkg

//--- verilog/ptv_window.sv
/*
 * Address windows for PCI target images 6 and 7 of a PCI-to-VMEbus bridge:
 * register file on Avalon-MM, decode, translation and cycle attributes.
 * Assumes the PCI target and the VMEbus master engine sit outside and use the
 * registered decode result one clock after the request is presented.
 */
// Functional notes
// [R1] An image claims an address only when it is at or above base and below limit.
// [R2] A limit of zero makes the window open-ended above the base.
// [R3] Images 6 and 7 compare the limit at 64 Kbyte granularity (bits 31 to 16).
// [R4] VMEbus address bits 31 to 16 are PCI bits 31 to 16 plus the offset, two's complement.
// [R5] Base, limit and offset live in bits 31 to 16, read/write, low bits reserved, reset zero.
// [R6] Width codes 00, 01, 10, 11 give 8, 16, 32, 64 bits and reset to 10.
// [R7] Space codes give A16, A24, A32, CR/CSR, User1, User2; 011 and 100 are reserved.
// [R8] Program/data select gives data AM codes at 0 and program AM codes at 1.
// [R9] Privilege select gives non-privileged AM codes at 0 and supervisory at 1.
// [R10] Block-transfer allow permits block transfers when set and forbids them when clear.
// [R11] Block-transfer allow counts only for A24 or A32 with 8, 16 or 32 bit width.
// [R12] With A24 or A32 and 64-bit width, MBLT may be used whatever block-transfer allow says.
// [R13] Posted write allow enables posting at 1, disables at 0, and resets to 0.
// [R14] In PCI I/O space posting is ignored and every transfer is coupled.
// [R15] PCI space select picks memory space at 0 and I/O space at 1.
// [R16] An image decodes only while its window-on bit is 1, which resets to 0.
`timescale 1ns/10ps
`include "ptv_params.svh"

module ptv_window #(
   parameter int ADDR_W = 12
) (
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   input  wire logic [ADDR_W-1:0]     avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output      logic [31:0]           avs_readdata,
   output      logic                  avs_waitrequest,
   output      logic [1:0]            avs_response,
   input  wire ptv_pkg::ptv_pci_req_t pci_req,
   output      ptv_pkg::ptv_vme_req_t vme_req
);

   // -------------------------------------------------------------------------
   // Register storage
   // -------------------------------------------------------------------------
   ptv_pkg::ptv_ctl_t ctl_q   [2];
   logic [15:0]       base_q  [2];
   logic [15:0]       bound_q [2];
   logic [15:0]       xoff_q  [2];

   logic              ack_q;
   logic [31:0]       rdata_q;
   logic [1:0]        resp_q;

   logic              acc;
   logic              img;
   logic [2:0]        sel;
   logic              mapped;

   // Bus decode: sel 0=ctl 1=base 2=bound 3=offset
   always_comb begin
      mapped = 1'b1;
      img    = 1'b0;
      sel    = 3'h0;
      unique case (avs_address)
         `PTV_OFF_IMG6_CTL:   sel = 3'h0;
         `PTV_OFF_IMG6_BASE:  sel = 3'h1;
         `PTV_OFF_IMG6_BOUND: sel = 3'h2;
         `PTV_OFF_IMG6_XOFF:  sel = 3'h3;
         `PTV_OFF_IMG7_CTL:   begin img = 1'b1; sel = 3'h0; end
         `PTV_OFF_IMG7_BASE:  begin img = 1'b1; sel = 3'h1; end
         `PTV_OFF_IMG7_BOUND: begin img = 1'b1; sel = 3'h2; end
         `PTV_OFF_IMG7_XOFF:  begin img = 1'b1; sel = 3'h3; end
         default:             mapped = 1'b0;
      endcase
   end

   assign acc             = (avs_read | avs_write) & ~ack_q;
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign avs_readdata    = rdata_q;
   assign avs_response    = resp_q;

   // -------------------------------------------------------------------------
   // Bus handshake: one wait state, answer on the second edge
   // -------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= acc;
      end
   end

   function automatic logic [31:0] ctl_word(input ptv_pkg::ptv_ctl_t c);
      logic [31:0] w;
      w                                      = 32'h0000_0000;
      w[`PTV_CTL_EN_BIT]                     = c.window_on;
      w[`PTV_CTL_POSTED_WRITE_ALLOW_BIT]                   = c.posted_write_allow;
      w[`PTV_CTL_VDW_HI:`PTV_CTL_VDW_LO]     = c.max_vme_width;
      w[`PTV_CTL_VAS_HI:`PTV_CTL_VAS_LO]     = c.vme_space_select;
      w[`PTV_CTL_PGM_BIT]                    = c.program_data_select;
      w[`PTV_CTL_SUP_BIT]                    = c.supervisor_select;
      w[`PTV_CTL_VCT_BIT]                    = c.block_transfer_allow;
      w[`PTV_CTL_LAS_BIT]                    = c.pci_space_select;
      return w;
   endfunction : ctl_word

   // Read data and response, latched when the access is taken
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rdata_q <= 32'h0000_0000;
         resp_q  <= 2'h0;
      end else if (acc) begin
         resp_q  <= mapped ? 2'h0 : 2'h3;
         rdata_q <= 32'h0000_0000;
         if (avs_read && mapped) begin
            unique case (sel)
               3'h0:    rdata_q <= ctl_word(ctl_q[img]);
               3'h1:    rdata_q <= {base_q[img], 16'h0000};   // R5
               3'h2:    rdata_q <= {bound_q[img], 16'h0000};  // R5
               default: rdata_q <= {xoff_q[img], 16'h0000};   // R5
            endcase
         end
      end
   end

   // -------------------------------------------------------------------------
   // Register writes, byte lanes honoured
   // -------------------------------------------------------------------------
   logic wr_go;
   assign wr_go = acc & avs_write & mapped;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         for (int i = 0; i < 2; i++) begin
            ctl_q[i]                      <= '0;                    // R16
            ctl_q[i].max_vme_width        <= ptv_pkg::ptv_width_t'(`PTV_RST_VDW); // R6
            ctl_q[i].posted_write_allow   <= 1'b0;                  // R13
         end
      end else if (wr_go && sel == 3'h0) begin
         if (avs_byteenable[3]) begin
            ctl_q[img].window_on          <= avs_writedata[`PTV_CTL_EN_BIT];
            ctl_q[img].posted_write_allow <= avs_writedata[`PTV_CTL_POSTED_WRITE_ALLOW_BIT];
         end
         if (avs_byteenable[2]) begin
            ctl_q[img].max_vme_width      <= ptv_pkg::ptv_width_t'(
                                             avs_writedata[`PTV_CTL_VDW_HI:`PTV_CTL_VDW_LO]);
            ctl_q[img].vme_space_select   <= ptv_pkg::ptv_space_t'(
                                             avs_writedata[`PTV_CTL_VAS_HI:`PTV_CTL_VAS_LO]);
         end
         if (avs_byteenable[1]) begin
            ctl_q[img].program_data_select  <= avs_writedata[`PTV_CTL_PGM_BIT];
            ctl_q[img].supervisor_select    <= avs_writedata[`PTV_CTL_SUP_BIT];
            ctl_q[img].block_transfer_allow <= avs_writedata[`PTV_CTL_VCT_BIT];
         end
         if (avs_byteenable[0]) begin
            ctl_q[img].pci_space_select   <= avs_writedata[`PTV_CTL_LAS_BIT];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         for (int i = 0; i < 2; i++) begin
            base_q[i]  <= `PTV_RST_ADDR;                            // R5
            bound_q[i] <= `PTV_RST_ADDR;
            xoff_q[i]  <= `PTV_RST_ADDR;
         end
      end else if (wr_go) begin
         for (int b = 0; b < 2; b++) begin
            if (avs_byteenable[2+b]) begin
               unique case (sel)
                  3'h1:    base_q[img][8*b +: 8]  <= avs_writedata[16+8*b +: 8]; // R5
                  3'h2:    bound_q[img][8*b +: 8] <= avs_writedata[16+8*b +: 8]; // R5
                  3'h3:    xoff_q[img][8*b +: 8]  <= avs_writedata[16+8*b +: 8]; // R5
                  default: ;
               endcase
            end
         end
      end
   end

   // -------------------------------------------------------------------------
   // Window decode and translation
   // -------------------------------------------------------------------------
   logic [1:0]  hit;
   logic        pick;
   logic [15:0] page;

   logic [1:0]  on_ok;
   logic [1:0]  spc_ok;
   logic [1:0]  lo_ok;
   logic [1:0]  hi_ok;
   logic [1:0]  open_up;

   assign page = pci_req.addr[31:16];                               // R3

   // Compare terms, one set per image
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         on_ok[i]   = ctl_q[i].window_on;                           // R16
         spc_ok[i]  = pci_req.is_io == ctl_q[i].pci_space_select;   // R15
         lo_ok[i]   = page >= base_q[i];                            // R1
         open_up[i] = bound_q[i] == 16'h0000;                       // R2
         hi_ok[i]   = open_up[i] | (page < bound_q[i]);             // R1
      end
   end

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         hit[i] = pci_req.valid
                & on_ok[i]
                & spc_ok[i]
                & lo_ok[i]
                & hi_ok[i];
      end
   end

   // Image 6 wins when both windows claim the address
   assign pick = ~hit[0];

   // -------------------------------------------------------------------------
   // Attributes of the chosen image
   // -------------------------------------------------------------------------
   ptv_pkg::ptv_ctl_t sel_ctl;
   logic [15:0]       sel_xoff;
   logic [15:0]       vme_hi;
   logic              any_hit;
   logic              a2432;
   logic              wide64;
   logic              rsv_space;

   assign sel_ctl  = ctl_q[pick];
   assign sel_xoff = xoff_q[pick];
   assign any_hit  = |hit;

   // Upper address wraps at 16 bits, as a two's complement offset should
   assign vme_hi = 16'(page + sel_xoff);                            // R4

   assign a2432 = (sel_ctl.vme_space_select == ptv_pkg::PTV_A24)
                | (sel_ctl.vme_space_select == ptv_pkg::PTV_A32);

   assign wide64 = sel_ctl.max_vme_width == ptv_pkg::PTV_W64;

   assign rsv_space = (sel_ctl.vme_space_select == ptv_pkg::PTV_RSV3)
                    | (sel_ctl.vme_space_select == ptv_pkg::PTV_RSV4); // R7

   // -------------------------------------------------------------------------
   // Registered decode result, one flop group per concern
   // -------------------------------------------------------------------------
   logic                hit_q;
   logic                image_q;
   logic [31:0]         vaddr_q;
   ptv_pkg::ptv_width_t width_q;
   ptv_pkg::ptv_space_t space_q;
   logic                space_bad_q;
   logic                program_am_q;
   logic                super_am_q;
   logic                blt_use_q;
   logic                mblt_allow_q;
   logic                posted_q;

   // Claim and chosen image
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         hit_q   <= 1'b0;
         image_q <= 1'b0;
      end else begin
         hit_q   <= any_hit;                                        // R1 R2 R16
         image_q <= pick;
      end
   end

   // Translated address; the low half passes straight through
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         vaddr_q <= 32'h0000_0000;
      end else begin
         vaddr_q <= {vme_hi, pci_req.addr[15:0]};                   // R4
      end
   end

   // Data width for the engine
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         width_q <= ptv_pkg::PTV_W8;
      end else begin
         width_q <= sel_ctl.max_vme_width;                          // R6
      end
   end

   // Address space for the engine
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         space_q <= ptv_pkg::PTV_A16;
      end else begin
         space_q <= sel_ctl.vme_space_select;                       // R7
      end
   end

   // Reserved space codes are flagged so the engine can refuse them
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         space_bad_q <= 1'b0;
      end else begin
         space_bad_q <= rsv_space;                                  // R7
      end
   end

   // Program or data address-modifier codes
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         program_am_q <= 1'b0;
      end else begin
         program_am_q <= sel_ctl.program_data_select;               // R8
      end
   end

   // Supervisory or non-privileged address-modifier codes
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         super_am_q <= 1'b0;
      end else begin
         super_am_q <= sel_ctl.supervisor_select;                   // R9
      end
   end

   // Block transfers only in A24 or A32 below 64-bit width
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         blt_use_q <= 1'b0;
      end else begin
         blt_use_q <= sel_ctl.block_transfer_allow
                    & a2432 & ~wide64;                              // R10 R11
      end
   end

   // Multiplexed block transfers do not look at the allow bit
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         mblt_allow_q <= 1'b0;
      end else begin
         mblt_allow_q <= a2432 & wide64;                            // R12
      end
   end

   // Posting needs a claimed write through a memory-space image;
   // an I/O image always runs coupled whatever its allow bit says
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         posted_q <= 1'b0;
      end else begin
         posted_q <= any_hit & sel_ctl.posted_write_allow
                   & pci_req.is_write & ~sel_ctl.pci_space_select;  // R13 R14
      end
   end

   // Output carrier
   always_comb begin
      vme_req            = '0;
      vme_req.hit        = hit_q;
      vme_req.image      = image_q;
      vme_req.vme_addr   = vaddr_q;
      vme_req.width      = width_q;
      vme_req.space      = space_q;
      vme_req.space_bad  = space_bad_q;
      vme_req.program_am = program_am_q;
      vme_req.super_am   = super_am_q;
      vme_req.blt_use    = blt_use_q;
      vme_req.mblt_allow = mblt_allow_q;
      vme_req.posted     = posted_q;
   end

endmodule : ptv_window

//--- tb/ptv_window_assertions.sv
/* Concurrent checks on the target window ports.
   Assumes it is bound to ptv_window from the bench top. */
`timescale 1ns/10ps
`include "ptv_params.svh"
module ptv_window_assertions #(
   parameter int ADDR_W = 12
) (
   input wire logic                  clk,
   input wire logic                  rst_b,
   input wire logic [ADDR_W-1:0]     avs_address,
   input wire logic                  avs_read,
   input wire logic                  avs_write,
   input wire logic [31:0]           avs_readdata,
   input wire logic                  avs_waitrequest,
   input wire logic [1:0]            avs_response,
   input wire ptv_pkg::ptv_pci_req_t pci_req,
   input wire ptv_pkg::ptv_vme_req_t vme_req
);
   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic rd_ok;
   logic mapped;
   logic a24_32;
   assign rd_ok  = avs_read && !avs_waitrequest;
   assign mapped = avs_address inside {`PTV_OFF_IMG6_CTL, `PTV_OFF_IMG6_BASE,
      `PTV_OFF_IMG6_BOUND, `PTV_OFF_IMG6_XOFF, `PTV_OFF_IMG7_CTL, `PTV_OFF_IMG7_BASE,
      `PTV_OFF_IMG7_BOUND, `PTV_OFF_IMG7_XOFF};
   assign a24_32 = vme_req.space inside {ptv_pkg::PTV_A24, ptv_pkg::PTV_A32};
   answer_bound_a: assert property ((avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
      else $error("bus answer late");
   unmapped_resp_a: assert property (rd_ok && !mapped |-> avs_response == 2'h3
      && avs_readdata == 32'h0) else $error("unmapped read answer wrong");
   reserved_low_a: assert property (rd_ok && mapped && avs_address != `PTV_OFF_IMG7_CTL
      && avs_address != `PTV_OFF_IMG6_CTL |-> avs_readdata[15:0] == 16'h0)
      else $error("reserved bits not zero");
   idle_no_hit_a: assert property (!$past(pci_req.valid) |-> !vme_req.hit)
      else $error("hit without request");
   low_addr_a: assert property (vme_req.hit |->
      vme_req.vme_addr[15:0] == $past(pci_req.addr[15:0])) else $error("low address changed");
   posted_io_a: assert property (vme_req.posted |->
      $past(pci_req.is_write) && !$past(pci_req.is_io)) else $error("bad posting");
   blt_gate_a: assert property (vme_req.blt_use |-> a24_32
      && vme_req.width != ptv_pkg::PTV_W64) else $error("block transfer not allowed");
   mblt_gate_a: assert property (vme_req.hit |->
      vme_req.mblt_allow == (a24_32 && vme_req.width == ptv_pkg::PTV_W64))
      else $error("multiplexed block flag wrong");
   space_bad_a: assert property (vme_req.hit |-> vme_req.space_bad ==
      (vme_req.space inside {ptv_pkg::PTV_RSV3, ptv_pkg::PTV_RSV4})) else $error("space flag wrong");
endmodule : ptv_window_assertions

//--- tb/ptv_pci_master.sv
/* PCI master model presenting one target access per call.
   Assumes the caller enters access just after a rising edge. */
`timescale 1ns/10ps
module ptv_pci_master (
   input  wire logic            clk,
   output ptv_pkg::ptv_pci_req_t req
);
   // ---------------------------------------------------------------
   // Access
   // ---------------------------------------------------------------
   initial req = '0;
   task automatic access(input logic [31:0] a, input logic io, input logic wr);
      @(posedge clk);
      req <= '{valid: 1'b1, addr: a, is_io: io, is_write: wr};
      @(posedge clk);
      // Released lines show a changed pattern, never the last value
      req <= '{valid: 1'b0, addr: ~a, is_io: !io, is_write: !wr};
   endtask : access
endmodule : ptv_pci_master

//--- tb/tb.sv
/* Self-checking bench for the target window block.
   Assumes the design package, header and the two bench modules compile first. */
`timescale 1ns/10ps
`include "ptv_params.svh"
`define TB_CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
   $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb;
   logic                  clk = 1'b0;
   logic                  rst_b = 1'b0;
   logic [11:0]           avs_address = 12'h000;
   logic                  avs_read = 1'b0;
   logic                  avs_write = 1'b0;
   logic [31:0]           avs_writedata = 32'h0;
   logic [31:0]           avs_readdata;
   logic                  avs_waitrequest;
   logic [1:0]            avs_response;
   logic [1:0]            rsp;
   logic [31:0]           q;
   ptv_pkg::ptv_pci_req_t pci_req;
   ptv_pkg::ptv_vme_req_t vme_req;
   int                    error_cnt = 0;
   int                    compares = 0;
   localparam logic [11:0] OFFS [8] = '{`PTV_OFF_IMG6_CTL, `PTV_OFF_IMG6_BASE,
      `PTV_OFF_IMG6_BOUND, `PTV_OFF_IMG6_XOFF, `PTV_OFF_IMG7_CTL, `PTV_OFF_IMG7_BASE,
      `PTV_OFF_IMG7_BOUND, `PTV_OFF_IMG7_XOFF};
   always #5 clk = ~clk;
   ptv_window #(.ADDR_W(12)) dut_u (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .avs_response(avs_response), .pci_req(pci_req), .vme_req(vme_req));
   ptv_pci_master m_u (.clk(clk), .req(pci_req));
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic print_verdict();
      $display("counts compares=%0d error_cnt=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : print_verdict
   task automatic rw(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      avs_read <= !w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= d;
      for (n = 0; n < 9; n++) begin
         @(posedge clk);
         if (!avs_waitrequest) break;
      end
      q = avs_readdata;
      rsp = avs_response;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n == 9) begin
         error_cnt++;
         print_verdict();
      end
   endtask : rw
   function automatic logic [31:0] ctl(input logic en, pw, input logic [1:0] w,
      input logic [2:0] s, input logic pg, su, vc, ls);
      return {en, pw, 6'h00, w, 3'h0, s, 1'h0, pg, 1'h0, su, 3'h0, vc, 7'h00, ls};
   endfunction : ctl
   task automatic dec(input logic [31:0] a, input logic io, wr, hit, img, input logic [31:0] va);
      m_u.access(a, io, wr);
      #1;
      `TB_CHK("hit", hit, vme_req.hit)
      if (hit) `TB_CHK("image", img, vme_req.image)
      if (hit) `TB_CHK("vme_addr", va, vme_req.vme_addr)
   endtask : dec
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      for (int i = 0; i < 8; i++) begin
         rw(1'b0, OFFS[i], 32'h0);
         `TB_CHK("reset value", (i % 4 == 0) ? 32'h0080_0000 : 32'h0, q)
      end
      rw(1'b1, 12'h1D8, 32'hFFFF_FFFF);
      rw(1'b0, 12'h1D8, 32'h0);
      `TB_CHK("unmapped data", 32'h0, q)
      `TB_CHK("unmapped resp", 2'h3, rsp)
      dec(32'h0000_1000, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0);
      $display("test reset done");
   endtask : t_reset
   task automatic t_window();
      rw(1'b1, `PTV_OFF_IMG7_CTL, ctl(1, 0, 2'h2, 3'h2, 0, 0, 0, 0));
      rw(1'b1, `PTV_OFF_IMG7_BASE, 32'h1000_FFFF);
      rw(1'b1, `PTV_OFF_IMG7_BOUND, 32'h1002_0000);
      rw(1'b1, `PTV_OFF_IMG7_XOFF, 32'hF000_0000);
      rw(1'b0, `PTV_OFF_IMG7_BASE, 32'h0);
      `TB_CHK("base", 32'h1000_0000, q)
      dec(32'h1000_1234, 1'b0, 1'b0, 1'b1, 1'b1, 32'h0000_1234);
      dec(32'h1001_FFFF, 1'b0, 1'b1, 1'b1, 1'b1, 32'h0001_FFFF);
      dec(32'h1002_0000, 1'b0, 1'b0, 1'b0, 1'b1, 32'h0);
      dec(32'h0FFF_FFFF, 1'b0, 1'b0, 1'b0, 1'b1, 32'h0);
      dec(32'h1000_0000, 1'b1, 1'b0, 1'b0, 1'b1, 32'h0);
      rw(1'b1, `PTV_OFF_IMG7_BOUND, 32'h0);
      dec(32'hFFFF_0000, 1'b0, 1'b0, 1'b1, 1'b1, 32'hEFFF_0000);
      $display("test window done");
   endtask : t_window
   task automatic t_attr();
      for (int w = 0; w < 4; w++) for (int s = 0; s < 8; s++) begin
         rw(1'b1, `PTV_OFF_IMG6_CTL, ctl(1, 1, w[1:0], s[2:0], 1, 1, 1, 0));
         dec(32'h2000_0000, 1'b0, 1'b1, 1'b1, 1'b0, 32'h2000_0000);
         `TB_CHK("width", w[1:0], vme_req.width)
         `TB_CHK("space", s[2:0], vme_req.space)
         `TB_CHK("am bits", 2'h3, {vme_req.program_am, vme_req.super_am})
         `TB_CHK("blt", (s == 1 || s == 2) && w != 3, vme_req.blt_use)
         `TB_CHK("mblt", (s == 1 || s == 2) && w == 3, vme_req.mblt_allow)
         `TB_CHK("posted", 1'b1, vme_req.posted)
         `TB_CHK("bad space", s == 3 || s == 4, vme_req.space_bad)
      end
      $display("test attributes done");
   endtask : t_attr
   task automatic t_io();
      rw(1'b1, `PTV_OFF_IMG6_CTL, ctl(1, 1, 2'h2, 3'h2, 0, 0, 0, 1));
      dec(32'h2000_0000, 1'b1, 1'b1, 1'b1, 1'b0, 32'h2000_0000);
      `TB_CHK("io posted", 1'b0, vme_req.posted)
      `TB_CHK("am bits", 3'h0, {vme_req.program_am, vme_req.super_am, vme_req.blt_use})
      dec(32'h2000_0000, 1'b0, 1'b1, 1'b1, 1'b1, 32'h1000_0000);
      $display("test io done");
   endtask : t_io
   initial begin
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_window();
      t_attr();
      t_io();
      print_verdict();
   end
endmodule : tb
bind ptv_window ptv_window_assertions #(.ADDR_W(ADDR_W)) chk_u (.clk(clk), .rst_b(rst_b),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .avs_response(avs_response), .pci_req(pci_req), .vme_req(vme_req));
